// ==== bench/bus_ctrl_model.sv ====
// Behavioural bus controller that sends decoded commands and triggers.
`timescale 1ns/1ps
module bus_ctrl_model (
  input  wire logic        sys_clk,
  input  wire logic        cmd_ready,
  input  wire logic        get_done,
  output logic             cmd_valid,
  output logic [3:0]       cmd_code,
  output logic [15:0]      cmd_arg,
  output logic             get_pulse
);
  // Idle bus at time zero.
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 4'h0;
    cmd_arg   = 16'h0000;
    get_pulse = 1'b0;
  end
  // Holds a command until taken, then scrambles the released lines.
  task automatic send(input logic [3:0] c, input logic [15:0] a);
    int n;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code  = c;
    cmd_arg   = a;
    for (n = 0; n < 64 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_code  = ~c;
    cmd_arg   = ~a;
  endtask : send
  // Pulses a device trigger and waits for its handshake to finish.
  task automatic trig(output int n);
    @(negedge sys_clk);
    get_pulse = 1'b1;
    @(negedge sys_clk);
    get_pulse = 1'b0;
    for (n = 0; n < 64 && get_done !== 1'b1; n++) @(negedge sys_clk);
  endtask : trig
endmodule : bus_ctrl_model

// ==== bench/rank_checker_assertions.sv ====
// Port-level concurrent checks for the setting rank block.
`timescale 1ns/1ps
module rank_checker (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_code,
  input  wire logic [15:0] cmd_arg,
  input  wire logic        cmd_ready,
  input  wire logic        get_pulse,
  input  wire logic        get_done,
  input  wire logic [15:0] oper_volt,
  input  wire logic        hold_on,
  input  wire logic        error_lamp,
  input  wire logic        poll_err,
  input  wire logic        reply_valid,
  input  wire logic [8:0]  live_condition_register,
  input  wire logic [8:0]  accumulated_condition_register
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A command is taken on an edge where valid meets ready.
  wire       take = cmd_valid && cmd_ready;
  logic [4:0] stick_cnt;  // Open window after a sticky query is taken.
  // Only a recent sticky read may clear accumulated bits.
  always_ff @(posedge sys_clk) begin
    if (rst)
      stick_cnt <= 5'h0;
    else if (take && cmd_code == rank_pkg::CMD_STICKQ)
      stick_cnt <= 5'h1F;
    else if (stick_cnt != 5'h0)
      stick_cnt <= stick_cnt - 5'h1;
  end
  // One taken command of the given code.
  sequence take_of(logic [3:0] c);
    cmd_valid && cmd_ready && cmd_code == c;
  endsequence
  a_hold_off_write: assert property (take_of(rank_pkg::CMD_VSET) ##0 !hold_on
    |=> oper_volt == $past(cmd_arg) || (poll_err && $stable(oper_volt)))
    else $error("voltage not applied with hold off");
  a_hold_on_keeps: assert property (take_of(rank_pkg::CMD_VSET) ##0 hold_on
    |=> $stable(oper_volt))
    else $error("operating voltage changed while held");
  a_hold_arg_bit: assert property (take_of(rank_pkg::CMD_HOLD)
    |=> hold_on == $past(cmd_arg[0]))
    else $error("hold state differs from argument");
  a_get_answered: assert property (get_pulse && cmd_ready && !cmd_valid
    |-> ##[1:20] get_done)
    else $error("trigger handshake never completed");
  a_done_single: assert property (get_done |=> !get_done)
    else $error("trigger done longer than one cycle");
  a_error_all_marks: assert property ($rose(error_lamp)
    |-> poll_err ##[0:3] live_condition_register[7])
    else $error("error lamp without poll and condition bits");
  a_error_has_cause: assert property ($rose(error_lamp)
    |-> $past(take) || $past(take, 2))
    else $error("error lamp rose without a command");
  a_sticky_covers: assert property (!take_of(rank_pkg::CMD_STICKQ)
    |=> ($past(live_condition_register)
         & ~accumulated_condition_register) == 9'h000)
    else $error("live bit missing from sticky copy");
  a_sticky_keeps: assert property (|($past(accumulated_condition_register)
    & ~accumulated_condition_register) |-> stick_cnt != 5'h0)
    else $error("sticky bit cleared without a read");
  a_reply_single: assert property (reply_valid |=> !reply_valid)
    else $error("reply valid longer than one cycle");
  a_query_replies: assert property (take_of(rank_pkg::CMD_LIVEQ)
    |-> ##[2:40] reply_valid)
    else $error("condition query never answered");
endmodule : rank_checker

bind setting_rank_trigger_status rank_checker chk_i (
  .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
  .get_pulse(get_pulse), .get_done(get_done), .oper_volt(oper_volt),
  .hold_on(hold_on), .error_lamp(error_lamp), .poll_err(poll_err),
  .reply_valid(reply_valid),
  .live_condition_register(live_condition_register),
  .accumulated_condition_register(accumulated_condition_register));

// ==== bench/tb_top.sv ====
// Self-checking bench for the setting rank block.
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [3:0] c; logic [15:0] a, v, i;
    logic [1:0] p; logic [8:0] m; logic h;} row_t;
  logic        sys_clk = 1'b0;
  logic        rst, clr, cmd_valid, cmd_ready, get_pulse, get_done;
  logic        hold_on, error_lamp, poll_err, reply_valid;
  logic [3:0]  cmd_code;
  logic [15:0] cmd_arg, oper_volt, oper_curr;
  logic [1:0]  oper_prot;
  logic [8:0]  cond, oper_mask, live, acc;
  logic [11:0] reply_digits;
  int          errors = 0;
  int          comparisons = 0;
  int          n;
  // Command, argument, then the operating rank and hold state after it.
  row_t rows [9] = '{
    '{rank_pkg::CMD_VSET, 16'h0010, 16'h0010, 16'h0000, 2'h0, 9'h000, 1'b0},
    '{rank_pkg::CMD_ISET, 16'h0020, 16'h0010, 16'h0020, 2'h0, 9'h000, 1'b0},
    '{rank_pkg::CMD_PROT, 16'h0002, 16'h0010, 16'h0020, 2'h2, 9'h000, 1'b0},
    '{rank_pkg::CMD_MASK, 16'h0086, 16'h0010, 16'h0020, 2'h2, 9'h086, 1'b0},
    '{rank_pkg::CMD_HOLD, 16'h0001, 16'h0010, 16'h0020, 2'h2, 9'h086, 1'b1},
    '{rank_pkg::CMD_VSET, 16'h0030, 16'h0010, 16'h0020, 2'h2, 9'h086, 1'b1},
    '{rank_pkg::CMD_ISET, 16'h0040, 16'h0010, 16'h0020, 2'h2, 9'h086, 1'b1},
    '{rank_pkg::CMD_ADV,  16'h0000, 16'h0030, 16'h0040, 2'h2, 9'h086, 1'b1},
    '{rank_pkg::CMD_HOLD, 16'h0000, 16'h0030, 16'h0040, 2'h2, 9'h086, 1'b0}};
  always #25 sys_clk = ~sys_clk;
  bus_ctrl_model ctrl (.sys_clk(sys_clk), .cmd_ready(cmd_ready),
    .get_done(get_done), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_arg(cmd_arg), .get_pulse(get_pulse));
  setting_rank_trigger_status uut (.sys_clk(sys_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
    .cmd_ready(cmd_ready), .get_pulse(get_pulse), .get_done(get_done),
    .const_voltage_mode(cond[0]), .const_current_mode(cond[1]),
    .overrange(cond[2]), .voltage_protect_trip(cond[3]),
    .thermal_trip(cond[4]), .line_dropout(cond[5]),
    .mode_change_trip(cond[6]), .external_shutdown_input(cond[8]),
    .error_clear(clr), .oper_volt(oper_volt), .oper_curr(oper_curr),
    .oper_prot(oper_prot), .oper_mask(oper_mask), .hold_on(hold_on),
    .error_lamp(error_lamp), .poll_err(poll_err),
    .reply_valid(reply_valid), .reply_digits(reply_digits),
    .live_condition_register(live),
    .accumulated_condition_register(acc));
  ////////////////////////////////////////
  // Compares one value and counts a mismatch.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Sends a query and compares the decimal reply digits.
  task automatic ask(input logic [3:0] c, input logic [11:0] d);
    int k;
    ctrl.send(c, 16'h0000);
    for (k = 0; k < 60 && reply_valid !== 1'b1; k++) @(negedge sys_clk);
    chk({4'h0, reply_digits}, {4'h0, d});
  endtask : ask
  // Pulses the error clear and lets it settle.
  task automatic clear_err();
    clr = 1'b1;
    @(negedge sys_clk);
    clr = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : clear_err
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  ////////////////////////////////////////
  // Watchdog: the tests need well under two thousand cycles.
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    $display("watchdog expired");
    results();
  end
  // Main test sequence.
  initial begin
    rst = 1'b1;
    clr = 1'b0;
    cond = 9'h000;
    repeat (16) @(negedge sys_clk);
    chk(oper_volt, 16'h0000);
    chk({7'h0, acc}, 16'h0000);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    $display("test reset done");
    foreach (rows[k]) begin
      ctrl.send(rows[k].c, rows[k].a);
      chk(oper_volt, rows[k].v);
      chk(oper_curr, rows[k].i);
      chk({14'h0, oper_prot}, {14'h0, rows[k].p});
      chk({7'h0, oper_mask}, {7'h0, rows[k].m});
      chk({15'h0, hold_on}, {15'h0, rows[k].h});
    end
    $display("test rows done");
    ctrl.send(rank_pkg::CMD_HOLD, 16'h0001);
    ask(rank_pkg::CMD_HOLDQ, 12'h001);
    ctrl.send(rank_pkg::CMD_VSET, 16'h0050);
    chk(oper_volt, 16'h0030);
    ctrl.trig(n);
    chk(oper_volt, 16'h0050);
    chk({15'h0, n < 64}, 16'h0001);
    ctrl.send(rank_pkg::CMD_LIVEQ, 16'h0000);
    ctrl.trig(n);
    chk({15'h0, n > 6 && n < 64}, 16'h0001);
    chk({4'h0, reply_digits}, 16'h0000);
    ctrl.send(rank_pkg::CMD_HOLD, 16'h0000);
    $display("test trigger done");
    ctrl.send(rank_pkg::CMD_VLIM, 16'h0040);
    repeat (3) @(negedge sys_clk);
    chk({13'h0, error_lamp, poll_err, live[7]}, 16'h0007);
    clear_err();
    ctrl.send(rank_pkg::CMD_ILIM, 16'h0010);
    repeat (3) @(negedge sys_clk);
    chk({13'h0, error_lamp, poll_err, live[7]}, 16'h0007);
    clear_err();
    ctrl.send(rank_pkg::CMD_VLIM, 16'h0060);
    repeat (3) @(negedge sys_clk);
    chk({15'h0, live[7]}, 16'h0000);
    ctrl.send(rank_pkg::CMD_VSET, 16'h0070);
    repeat (3) @(negedge sys_clk);
    chk(oper_volt, 16'h0050);
    chk({13'h0, error_lamp, poll_err, live[7]}, 16'h0007);
    clear_err();
    $display("test limits done");
    ctrl.send(rank_pkg::CMD_SAVE, 16'h000F);
    ctrl.send(rank_pkg::CMD_VSET, 16'h0011);
    ctrl.send(rank_pkg::CMD_SAVE, 16'h0000);
    ctrl.send(rank_pkg::CMD_VSET, 16'h0022);
    ctrl.send(rank_pkg::CMD_REST, 16'h000F);
    repeat (3) @(negedge sys_clk);
    chk(oper_volt, 16'h0050);
    chk(oper_curr, 16'h0040);
    ctrl.send(rank_pkg::CMD_REST, 16'h0000);
    repeat (3) @(negedge sys_clk);
    chk(oper_volt, 16'h0011);
    $display("test snapshots done");
    for (int k = 0; k < 9; k++) begin
      if (k != 7) begin
        cond = 9'h001 << k;
        repeat (5) @(negedge sys_clk);
        chk({7'h0, live}, {7'h0, cond});
      end
    end
    cond = 9'h012;
    repeat (5) @(negedge sys_clk);
    ask(rank_pkg::CMD_LIVEQ, 12'h018);
    ask(rank_pkg::CMD_STICKQ, 12'h511);
    repeat (2) @(negedge sys_clk);
    chk({7'h0, acc}, 16'h0012);
    cond = 9'h000;
    repeat (5) @(negedge sys_clk);
    chk({7'h0, live}, 16'h0000);
    chk({7'h0, acc}, 16'h0012);
    $display("test conditions done");
    results();
  end
endmodule : tb_top

// ==== src/bin_to_dec.sv ====
// Converts a nine-bit condition value into three BCD digits.
`timescale 1ns/1ps
module bin_to_dec (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [8:0]  value,
  output logic             done,
  output logic [11:0]      digits
);

  // Shift register and adjust stage of the double-dabble method.
  logic [8:0]  shift;
  logic [11:0] bcd;
  logic [3:0]  count;
  logic        busy;
  logic [11:0] adj;

  // Add three to each digit of five or more before shifting.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_adj
      assign adj[g*4 +: 4] = (bcd[g*4 +: 4] > 4'h4) ?
                             4'(bcd[g*4 +: 4] + 4'h3) : bcd[g*4 +: 4];
    end
  endgenerate

  // One bit per cycle; done pulses with the finished digits.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift  <= 9'h000;
      bcd    <= 12'h000;
      count  <= 4'h0;
      busy   <= 1'b0;
      done   <= 1'b0;
      digits <= 12'h000;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        shift <= value;
        bcd   <= 12'h000;
        count <= 4'(rank_pkg::CONV_CYC);
        busy  <= 1'b1;
      end else if (busy) begin
        if (count == 4'h0) begin
          busy   <= 1'b0;
          done   <= 1'b1;
          digits <= bcd;
        end else begin
          bcd   <= {adj[10:0], shift[8]};
          shift <= {shift[7:0], 1'b0};
          count <= 4'(count - 4'h1);
        end
      end
    end
  end

endmodule : bin_to_dec

// ==== src/rank_pkg.sv ====
// Package of constants and types for the setting rank and condition block.
package rank_pkg;

  // Widths of the programmable settings, the condition word and the slot number, and the slot count.
  localparam int VAL_W   = 16;
  localparam int PROT_W  = 2;
  localparam int MASK_W  = 9;
  localparam int COND_W  = 9;
  localparam int SLOT_W  = 4;
  localparam int SLOTS   = 16;

  // Condition bit positions, weights 1 to 256.
  localparam int BIT_CV   = 0;
  localparam int BIT_CC   = 1;
  localparam int BIT_OR   = 2;
  localparam int BIT_OVP  = 3;
  localparam int BIT_THM  = 4;
  localparam int BIT_LINE = 5;
  localparam int BIT_MCT  = 6;
  localparam int BIT_ERR  = 7;
  localparam int BIT_INH  = 8;

  // Values after reset.
  localparam logic [VAL_W-1:0]  VAL_RST   = 16'h0000;
  localparam logic [VAL_W-1:0]  LIMIT_RST = 16'hFFFF;
  localparam logic [PROT_W-1:0] PROT_RST  = 2'h0;
  localparam logic [MASK_W-1:0] MASK_RST  = 9'h000;
  localparam logic [COND_W-1:0] COND_RST  = 9'h000;

  // Decoded command codes presented by the bus front end.
  typedef enum logic [3:0] {
    CMD_VSET   = 4'h1,
    CMD_ISET   = 4'h2,
    CMD_PROT   = 4'h3,
    CMD_MASK   = 4'h4,
    CMD_VLIM   = 4'h5,
    CMD_ILIM   = 4'h6,
    CMD_HOLD   = 4'h7,
    CMD_ADV    = 4'h8,
    CMD_SAVE   = 4'h9,
    CMD_REST   = 4'hA,
    CMD_LIVEQ  = 4'hB,
    CMD_STICKQ = 4'hC,
    CMD_HOLDQ  = 4'hD
  } cmd_t;

  // Digit conversion shift count: one cycle per binary bit; the load and done cycles come on top.
  localparam int CONV_CYC = COND_W;

endpackage : rank_pkg

// ==== src/setting_rank_trigger_status.sv ====
// Two-rank settings store with trigger, snapshots and condition registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module setting_rank_trigger_status (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          cmd_valid,
  input  wire logic [3:0]                    cmd_code,
  input  wire logic [rank_pkg::VAL_W-1:0]    cmd_arg,
  output logic                               cmd_ready,
  input  wire logic                          get_pulse,
  output logic                               get_done,
  input  wire logic                          const_voltage_mode,
  input  wire logic                          const_current_mode,
  input  wire logic                          overrange,
  input  wire logic                          voltage_protect_trip,
  input  wire logic                          thermal_trip,
  input  wire logic                          line_dropout,
  input  wire logic                          mode_change_trip,
  input  wire logic                          external_shutdown_input,
  input  wire logic                          error_clear,
  output logic [rank_pkg::VAL_W-1:0]         oper_volt,
  output logic [rank_pkg::VAL_W-1:0]         oper_curr,
  output logic [rank_pkg::PROT_W-1:0]        oper_prot,
  output logic [rank_pkg::MASK_W-1:0]        oper_mask,
  output logic                               hold_on,
  output logic                               error_lamp,
  output logic                               poll_err,
  output logic                               reply_valid,
  output logic [11:0]                        reply_digits,
  output logic [rank_pkg::COND_W-1:0]        live_condition_register,
  output logic [rank_pkg::COND_W-1:0]        accumulated_condition_register
);

  //////////////////////////////////////////////////////////////////////////////
  // Local types and storage.

  // Control sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_LOAD = 4'b0100,
    ST_CONV = 4'b1000
  } state_t;

  localparam int SNAP_W = 2 * rank_pkg::VAL_W + rank_pkg::PROT_W
                          + rank_pkg::MASK_W + 2;

  state_t state;                                  // Sequencer state.
  state_t next_state;                             // Next sequencer state.

  logic [rank_pkg::VAL_W-1:0]  pend_volt;         // Pending voltage.
  logic [rank_pkg::VAL_W-1:0]  pend_curr;         // Pending current.
  logic [rank_pkg::PROT_W-1:0] pend_prot;         // Pending protect mode.
  logic [rank_pkg::MASK_W-1:0] pend_mask;         // Pending mask.
  logic [rank_pkg::VAL_W-1:0]  volt_limit;        // Voltage soft limit.
  logic [rank_pkg::VAL_W-1:0]  curr_limit;        // Current soft limit.
  logic                        prog_error;        // Programming error flag.
  logic                        get_pending;       // Trigger waiting.
  logic [rank_pkg::SLOT_W-1:0] rest_slot;         // Slot of a restore.

  // Synchronised condition inputs; first stage read only by second.
  logic [7:0] cond_meta;
  logic [7:0] cond_sync;

  // Snapshot and digit converter links.
  logic [SNAP_W-1:0] snap_rd;
  logic [SNAP_W-1:0] snap_wr;
  logic              conv_start;
  logic              conv_done;
  logic [11:0]       conv_digits;
  logic [rank_pkg::COND_W-1:0] conv_value;

  //////////////////////////////////////////////////////////////////////////////
  // Command decode.

  // Accepted command strobes.
  wire take       = cmd_valid && cmd_ready;
  wire is_vset    = take && cmd_code == rank_pkg::CMD_VSET;
  wire is_iset    = take && cmd_code == rank_pkg::CMD_ISET;
  wire is_prot    = take && cmd_code == rank_pkg::CMD_PROT;
  wire is_mask    = take && cmd_code == rank_pkg::CMD_MASK;
  wire is_vlim    = take && cmd_code == rank_pkg::CMD_VLIM;
  wire is_ilim    = take && cmd_code == rank_pkg::CMD_ILIM;
  wire is_hold    = take && cmd_code == rank_pkg::CMD_HOLD;
  wire is_adv     = take && cmd_code == rank_pkg::CMD_ADV;
  wire is_save    = take && cmd_code == rank_pkg::CMD_SAVE;
  wire is_rest    = take && cmd_code == rank_pkg::CMD_REST;
  wire is_liveq   = take && cmd_code == rank_pkg::CMD_LIVEQ;
  wire is_stickq  = take && cmd_code == rank_pkg::CMD_STICKQ;
  wire is_holdq   = take && cmd_code == rank_pkg::CMD_HOLDQ;

  // Limit checks on new values and on new limits.
  wire v_over     = cmd_arg > volt_limit;
  wire i_over     = cmd_arg > curr_limit;
  wire vlim_bad   = cmd_arg < pend_volt || cmd_arg < oper_volt;
  wire ilim_bad   = cmd_arg < pend_curr || cmd_arg < oper_curr;
  wire bad_value  = (is_vset && v_over) || (is_iset && i_over);
  wire bad_limit  = (is_vlim && vlim_bad) || (is_ilim && ilim_bad);
  wire good_vset  = is_vset && !v_over;
  wire good_iset  = is_iset && !i_over;

  // Copy pending to operating on advance or bus trigger.
  wire fire_get   = state == ST_IDLE && get_pending && !cmd_valid;
  wire advance    = is_adv || fire_get;
  wire restored   = state == ST_LOAD;
  wire direct     = !hold_on;

  // The bus may drop the argument after the take, so a restore reads
  // the slot number that was captured when it was taken.
  wire [rank_pkg::SLOT_W-1:0] store_slot = (state == ST_IDLE) ?
    cmd_arg[rank_pkg::SLOT_W-1:0] : rest_slot;

  // Snapshot layout; output on/off lives outside this block.
  assign snap_wr = {pend_volt, pend_curr, pend_prot, pend_mask,
                    hold_on, 1'b0};

  // Live conditions in documented bit order.
  wire [rank_pkg::COND_W-1:0] next_live = {cond_sync[7], prog_error,
                                           cond_sync[6:0]};

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer: reads a snapshot slot or runs a digit conversion.

  // Next-state logic.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (is_rest) begin
          next_state = ST_READ;
        end else if (is_liveq || is_stickq || is_holdq) begin
          next_state = ST_CONV;
        end
      end
      ST_READ: next_state = ST_LOAD;
      ST_LOAD: next_state = ST_IDLE;
      ST_CONV: begin
        if (conv_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Converter launch and value selection.
  assign conv_start = is_liveq || is_stickq || is_holdq;
  assign conv_value = is_holdq ? {8'h00, hold_on} :
                      is_stickq ? accumulated_condition_register :
                      live_condition_register;

  //////////////////////////////////////////////////////////////////////////////
  // State register and handshakes.

  // Ready only while the next state is idle and no query or restore is being taken.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state       <= ST_IDLE;
      cmd_ready   <= 1'b0;
      get_pending <= 1'b0;
      get_done    <= 1'b0;
      rest_slot   <= '0;
    end else begin
      state     <= next_state;
      if (is_rest) rest_slot <= cmd_arg[rank_pkg::SLOT_W-1:0];
      cmd_ready <= next_state == ST_IDLE && !conv_start && !is_rest;
      get_done  <= fire_get;
      if (get_pulse) begin
        get_pending <= 1'b1;
      end else if (fire_get) begin
        get_pending <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pending rank and soft limits.

  // Values go to pending after passing their limit check.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_volt  <= rank_pkg::VAL_RST;
      pend_curr  <= rank_pkg::VAL_RST;
      pend_prot  <= rank_pkg::PROT_RST;
      pend_mask  <= rank_pkg::MASK_RST;
      volt_limit <= rank_pkg::LIMIT_RST;
      curr_limit <= rank_pkg::LIMIT_RST;
      hold_on    <= 1'b0;
    end else if (restored) begin
      // Saved settings return; on/off untouched.
      {pend_volt, pend_curr, pend_prot, pend_mask, hold_on} <=
        snap_rd[SNAP_W-1:1];
    end else begin
      if (good_vset) pend_volt <= cmd_arg;
      if (good_iset) pend_curr <= cmd_arg;
      if (is_prot) pend_prot <= cmd_arg[rank_pkg::PROT_W-1:0];
      if (is_mask) pend_mask <= cmd_arg[rank_pkg::MASK_W-1:0];
      if (is_vlim && !vlim_bad) volt_limit <= cmd_arg;
      if (is_ilim && !ilim_bad) curr_limit <= cmd_arg;
      if (is_hold) hold_on <= cmd_arg[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operating rank; only these drive the output stage.

  // Direct load with hold off, copy on advance, full load on restore.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oper_volt <= rank_pkg::VAL_RST;
      oper_curr <= rank_pkg::VAL_RST;
      oper_prot <= rank_pkg::PROT_RST;
      oper_mask <= rank_pkg::MASK_RST;
    end else if (restored) begin
      {oper_volt, oper_curr, oper_prot, oper_mask} <=
        snap_rd[SNAP_W-1:2];
    end else if (advance) begin
      oper_volt <= pend_volt;
      oper_curr <= pend_curr;
      oper_prot <= pend_prot;
      oper_mask <= pend_mask;
    end else if (direct) begin
      if (good_vset) oper_volt <= cmd_arg;
      if (good_iset) oper_curr <= cmd_arg;
      if (is_prot) oper_prot <= cmd_arg[rank_pkg::PROT_W-1:0];
      if (is_mask) oper_mask <= cmd_arg[rank_pkg::MASK_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Error flag and condition registers.

  // Error sets on a rejected value or limit; set wins over clear.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prog_error <= 1'b0;
      error_lamp <= 1'b0;
      poll_err   <= 1'b0;
    end else begin
      if (bad_value || bad_limit) begin
        prog_error <= 1'b1;
        error_lamp <= 1'b1;
        poll_err   <= 1'b1;
      end else if (error_clear) begin
        prog_error <= 1'b0;
        error_lamp <= 1'b0;
        poll_err   <= 1'b0;
      end
    end
  end

  // Two-stage sync of the outside condition lines.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cond_meta <= 8'h00;
      cond_sync <= 8'h00;
    end else begin
      cond_meta <= {external_shutdown_input, mode_change_trip, line_dropout,
                    thermal_trip, voltage_protect_trip, overrange,
                    const_current_mode, const_voltage_mode};
      cond_sync <= cond_meta;
    end
  end

  // Live follows conditions; sticky ORs them and reloads on read.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      live_condition_register        <= rank_pkg::COND_RST;
      accumulated_condition_register <= rank_pkg::COND_RST;
    end else begin
      live_condition_register <= next_live;
      if (is_stickq) begin
        accumulated_condition_register <= next_live;
      end else begin
        accumulated_condition_register <=
          accumulated_condition_register | next_live;
      end
    end
  end

  // Reply digits held until the next answer.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reply_valid  <= 1'b0;
      reply_digits <= 12'h000;
    end else begin
      reply_valid <= conv_done;
      if (conv_done) reply_digits <= conv_digits;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Submodules.

  // Slot number is four bits, so 0 to 15 only.
  snapshot_store #(
    .WIDTH (SNAP_W),
    .DEPTH (rank_pkg::SLOTS)
  ) u_store (
    .sys_clk (sys_clk),
    .wr_en   (is_save),
    .slot    (store_slot),
    .wr_data (snap_wr),
    .rd_data (snap_rd)
  );

  // Decimal conversion of query values.
  bin_to_dec u_conv (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (conv_start),
    .value   (conv_value),
    .done    (conv_done),
    .digits  (conv_digits)
  );

endmodule : setting_rank_trigger_status

// ==== src/snapshot_store.sv ====
// Sixteen-slot snapshot memory for the programmable state.
`timescale 1ns/1ps
module snapshot_store #(
  parameter int WIDTH = 45,
  parameter int DEPTH = rank_pkg::SLOTS
) (
  input  wire logic                     sys_clk,
  input  wire logic                     wr_en,
  input  wire logic [rank_pkg::SLOT_W-1:0] slot,
  input  wire logic [WIDTH-1:0]         wr_data,
  output logic      [WIDTH-1:0]         rd_data
);

  // Slot array; contents survive reset as stored presets do.
  logic [WIDTH-1:0] slots [DEPTH];

  // Write on save and register the read of the addressed slot.
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      slots[slot] <= wr_data;
    end
    rd_data <= slots[slot];
  end

endmodule : snapshot_store
